// *** verilog/ckg_pkg.sv ***
// constants, field layouts and carrier types of the system clock source select block
//
// Overview of operation
// - select 11 passes the direct clock pin straight to the system clock
// - select 10 with bypass set divides the reference source by prescaler value plus one
// - prescaler value zero passes the source unchanged, duty cycle included
// - prescaler divides by up to 1024
// - select 10 with bypass clear runs the loop and uses its output
// - loop scales input by feedback over input times output divider, each value plus one
// - loop and prescaler reference is the oscillator pin or the internal source
// - loop step moves one unit at a time, the error nudge shifts the frequency in units of 64
// - system clock in loop mode is the oscillator divided by the output divider
// - band 00 and 01 select oscillator ranges, writes of 1x are refused
// - select 00 takes the system clock from the wakeup source
package ckg_pkg;

	// ------------------------------------------------------------
	// field widths
	// ------------------------------------------------------------
	localparam int K1_W   = 10;
	localparam int INPUT_DIVIDE_VALUE_W = 4;
	localparam int FEEDBACK_MULTIPLY_VALUE_W = 7;
	localparam int K2_W   = 10;
	localparam int ACC_W  = 16;
	localparam int ERR_W  = 8;
	localparam int LOCK_W = 7;
	localparam int PROP_SH = 6;

	// ------------------------------------------------------------
	// register byte addresses
	// ------------------------------------------------------------
	localparam logic [31:0] SYS_CTRL_ADDR  = 32'h0000_0000;
	localparam logic [31:0] LOOP_CTRL_ADDR = 32'h0000_0004;
	localparam logic [31:0] STATUS_ADDR    = 32'h0000_0008;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int SEL_POS    = 0;
	localparam int K1_POS     = 16;
	localparam int BYP_POS    = 0;
	localparam int BAND_POS   = 1;
	localparam int REF_POS    = 3;
	localparam int INPUT_DIVIDE_VALUE_POS   = 4;
	localparam int FEEDBACK_MULTIPLY_VALUE_POS   = 8;
	localparam int K2_POS     = 16;
	localparam int LOCK_POS   = 2;
	localparam int STEP_POS   = 16;

	// ------------------------------------------------------------
	// encodings
	// ------------------------------------------------------------
	localparam logic [1:0] SEL_WAKEUP   = 2'h0;
	localparam logic [1:0] SEL_RESERVED = 2'h1;
	localparam logic [1:0] SEL_OSC      = 2'h2;
	localparam logic [1:0] SEL_DIRECT   = 2'h3;
	localparam logic [1:0] BAND_LOW     = 2'h0;
	localparam logic [1:0] BAND_HIGH    = 2'h1;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	// ------------------------------------------------------------
	// reset values and loop limits
	// ------------------------------------------------------------
	localparam logic [1:0]        SEL_RST  = SEL_WAKEUP;
	localparam logic              BYP_RST  = 1'b1;
	localparam logic [ACC_W-1:0]  STEP_MIN_LOW  = 16'h1000;
	localparam logic [ACC_W-1:0]  STEP_MAX_LOW  = 16'h4000;
	localparam logic [ACC_W-1:0]  STEP_MIN_HIGH = 16'h3000;
	localparam logic [ACC_W-1:0]  STEP_MAX_HIGH = 16'h6000;
	localparam logic signed [ERR_W-1:0] ERR_LIM = 8'sh40;
	localparam logic [LOCK_W-1:0] LOCK_PULSES = 7'h40;

	// ------------------------------------------------------------
	// carrier types
	// ------------------------------------------------------------
	typedef struct packed {
		logic [1:0]      sel;
		logic [K1_W-1:0] k1;
	} ckg_sys_cfg_t;

	typedef struct packed {
		logic              bypass;
		logic [1:0]        band;
		logic              ref_internal;
		logic [INPUT_DIVIDE_VALUE_W-1:0] input_divide_value;
		logic [FEEDBACK_MULTIPLY_VALUE_W-1:0] feedback_multiply_value;
		logic [K2_W-1:0]   k2;
	} ckg_loop_cfg_t;

	typedef struct packed {
		ckg_sys_cfg_t             sys;
		ckg_loop_cfg_t            loop;
		logic                     dp_valid;
		logic                     dp_write;
		logic [31:0]              dp_addr;
		logic [31:0]              hrdata;
		logic                     hreadyout;
		logic                     hresp;
		logic [ACC_W-1:0]         acc;
		logic                     vco;
		logic [ACC_W-1:0]         step;
		logic signed [ERR_W-1:0]  err;
		logic [LOCK_W-1:0]        lock_cnt;
		logic                     locked;
		logic                     sys_clock;
	} ckg_state_t;

endpackage

// *** verilog/ckg_edge_div.sv ***
// edge counting divider by value plus one, used for every divider of the block
module ckg_edge_div
	import ckg_pkg::*;
#(
	parameter int W = 10
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rstn,
	// control
	input  wire logic         ena,
	input  wire logic [W-1:0] div,
	// source and result
	input  wire logic         in_level,
	output logic              out_level,
	output logic              out_rise
);

	typedef struct packed {
		logic         prev;
		logic [W-1:0] cnt;
		logic         out;
		logic         rise;
	} ckg_div_st_t;

	ckg_div_st_t s;
	ckg_div_st_t next_s;

	logic         rise_in;
	logic [W-1:0] cnt_new;
	logic [W:0]   half;

	always_comb begin
		next_s = s;
		rise_in = in_level & ~s.prev;
		half = ({1'b0, div} + {{W{1'b0}}, 1'b1}) >> 1;
		cnt_new = (s.cnt == div) ? '0 : s.cnt + 1'b1;
		next_s.prev = in_level;
		next_s.rise = 1'b0;
		if (!ena) begin
			next_s.cnt = '0;
			next_s.out = 1'b0;
		end else if (div == '0) begin
			// pass-through keeps the source duty cycle
			next_s.out = in_level;
			next_s.rise = rise_in;
		end else if (rise_in) begin
			// only source rising edges are seen, so duty is exactly half only when value plus one is even
			next_s.cnt = cnt_new;
			next_s.out = {1'b0, cnt_new} < half;
			next_s.rise = (cnt_new == '0);
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign out_level = s.out;
	assign out_rise  = s.rise;

endmodule // ckg_edge_div

// *** verilog/ckg_system_clock_source_select.sv ***
// system clock source select with prescaler, loop and ahb-lite register slave
module ckg_system_clock_source_select
	import ckg_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rstn,
	// clock sources, sampled on clk
	input  wire logic        direct_clock_pin,
	input  wire logic        oscillator_input_pin,
	input  wire logic        internal_clock_source,
	input  wire logic        wakeup_clock_source,
	// ahb-lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	// clock result
	output logic             system_clock,
	output logic             loop_locked
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	ckg_state_t s;
	ckg_state_t next_s;

	logic              ref_level;
	logic              presc_mode;
	logic              loop_mode;
	logic              presc_out;
	logic              in_div_rise;
	logic              fb_rise;
	logic              out_div_out;
	logic              addr_take;
	logic [ACC_W:0]    acc_sum;
	logic [ACC_W-1:0]  nudge;
	logic [ACC_W-1:0]  step_min;
	logic [ACC_W-1:0]  step_max;
	logic signed [ERR_W-1:0] err_new;
	logic [31:0]       rd_val;

	// ------------------------------------------------------------
	// reference and mode decode
	// ------------------------------------------------------------
	// one reference for both prescaler and loop
	assign ref_level  = s.loop.ref_internal ? internal_clock_source : oscillator_input_pin;
	assign presc_mode = (s.sys.sel == SEL_OSC) & s.loop.bypass;
	assign loop_mode  = (s.sys.sel == SEL_OSC) & ~s.loop.bypass;

	// ------------------------------------------------------------
	// dividers
	// ------------------------------------------------------------
	// prescaler up to 1024
	ckg_edge_div #(.W(K1_W)) u_presc (
		.clk       (clk),
		.rstn      (rstn),
		.ena       (presc_mode),
		.div       (s.sys.k1),
		.in_level  (ref_level),
		.out_level (presc_out),
		.out_rise  ()
	);

	// loop input divider
	ckg_edge_div #(.W(INPUT_DIVIDE_VALUE_W)) u_in_div (
		.clk       (clk),
		.rstn      (rstn),
		.ena       (loop_mode),
		.div       (s.loop.input_divide_value),
		.in_level  (ref_level),
		.out_level (),
		.out_rise  (in_div_rise)
	);

	// loop feedback divider
	ckg_edge_div #(.W(FEEDBACK_MULTIPLY_VALUE_W)) u_fb_div (
		.clk       (clk),
		.rstn      (rstn),
		.ena       (loop_mode),
		.div       (s.loop.feedback_multiply_value),
		.in_level  (s.vco),
		.out_level (),
		.out_rise  (fb_rise)
	);

	// output divider on the oscillator
	ckg_edge_div #(.W(K2_W)) u_out_div (
		.clk       (clk),
		.rstn      (rstn),
		.ena       (loop_mode),
		.div       (s.loop.k2),
		.in_level  (s.vco),
		.out_level (out_div_out),
		.out_rise  ()
	);

	// ------------------------------------------------------------
	// band limits
	// ------------------------------------------------------------
	always_comb begin
		case (s.loop.band)
			BAND_LOW: begin
				step_min = STEP_MIN_LOW;
				step_max = STEP_MAX_LOW;
			end
			BAND_HIGH: begin
				step_min = STEP_MIN_HIGH;
				step_max = STEP_MAX_HIGH;
			end
			default: begin
				step_min = STEP_MIN_LOW;
				step_max = STEP_MAX_LOW;
			end
		endcase
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	assign addr_take = hsel & hready & (htrans == HTRANS_NONSEQ);
	// phase nudge from the error damps the step loop, up to 4096 either way, as large as the lowest low-band step
	assign nudge     = {{(ACC_W-ERR_W-PROP_SH){s.err[ERR_W-1]}}, s.err, {PROP_SH{1'b0}}};
	assign acc_sum   = {1'b0, s.acc} + {1'b0, s.step + nudge};

	always_comb begin
		next_s = s;
		err_new = s.err;
		rd_val = '0;

		// register writes in the data phase
		if (s.dp_valid && s.dp_write) begin
			case (s.dp_addr)
				SYS_CTRL_ADDR: begin
					// reserved select keeps the running source
					if (hwdata[SEL_POS +: 2] != SEL_RESERVED) begin
						next_s.sys.sel = hwdata[SEL_POS +: 2];
					end
					next_s.sys.k1 = hwdata[K1_POS +: K1_W];
				end
				LOOP_CTRL_ADDR: begin
					next_s.loop.bypass = hwdata[BYP_POS];
					// reserved bands 1x are refused
					if (hwdata[BAND_POS + 1] == 1'b0) begin
						next_s.loop.band = hwdata[BAND_POS +: 2];
					end
					next_s.loop.ref_internal = hwdata[REF_POS];
					next_s.loop.input_divide_value = hwdata[INPUT_DIVIDE_VALUE_POS +: INPUT_DIVIDE_VALUE_W];
					next_s.loop.feedback_multiply_value = hwdata[FEEDBACK_MULTIPLY_VALUE_POS +: FEEDBACK_MULTIPLY_VALUE_W];
					next_s.loop.k2 = hwdata[K2_POS +: K2_W];
				end
				default: begin
				end
			endcase
		end

		// loop: phase accumulator oscillator
		if (loop_mode) begin
			next_s.acc = acc_sum[ACC_W-1:0];
			if (acc_sum[ACC_W]) begin
				next_s.vco = ~s.vco;
			end
			// reference pulses count up, feedback pulses count down
			if (in_div_rise && !fb_rise && s.err < ERR_LIM) begin
				err_new = s.err + 8'sh01;
			end else if (fb_rise && !in_div_rise && s.err > -ERR_LIM) begin
				err_new = s.err - 8'sh01;
			end
			next_s.err = err_new;
			// one step per reference pulse inside the band, one per clock back into the band, keeps the frequency smooth
			if (s.step < step_min) begin
				next_s.step = s.step + 1'b1;
			end else if (s.step > step_max) begin
				next_s.step = s.step - 1'b1;
			// dead band of one pulse leaves the fine phase to the nudge
			end else if (in_div_rise && err_new > 8'sh01 && s.step < step_max) begin
				next_s.step = s.step + 1'b1;
			end else if (in_div_rise && err_new < -8'sh01 && s.step > step_min) begin
				next_s.step = s.step - 1'b1;
			end
			// lock only after a run of quiet reference pulses
			if (err_new > 8'sh01 || err_new < -8'sh01) begin
				next_s.lock_cnt = '0;
			end else if (in_div_rise && s.lock_cnt != LOCK_PULSES) begin
				next_s.lock_cnt = s.lock_cnt + 1'b1;
			end
			next_s.locked = (next_s.lock_cnt == LOCK_PULSES);
		end else begin
			next_s.acc = '0;
			next_s.vco = 1'b0;
			next_s.err = '0;
			next_s.lock_cnt = '0;
			next_s.locked = 1'b0;
		end

		// system clock mux
		case (s.sys.sel)
			SEL_DIRECT: next_s.sys_clock = direct_clock_pin;
			SEL_OSC:    next_s.sys_clock = s.loop.bypass ? presc_out
			                                             : out_div_out;
			SEL_WAKEUP: next_s.sys_clock = wakeup_clock_source;
			default:    next_s.sys_clock = s.sys_clock;
		endcase

		// read value from next values so a read right after a write sees it
		case (haddr)
			SYS_CTRL_ADDR: begin
				rd_val[SEL_POS +: 2] = next_s.sys.sel;
				rd_val[K1_POS +: K1_W] = next_s.sys.k1;
			end
			LOOP_CTRL_ADDR: begin
				rd_val[BYP_POS] = next_s.loop.bypass;
				rd_val[BAND_POS +: 2] = next_s.loop.band;
				rd_val[REF_POS] = next_s.loop.ref_internal;
				rd_val[INPUT_DIVIDE_VALUE_POS +: INPUT_DIVIDE_VALUE_W] = next_s.loop.input_divide_value;
				rd_val[FEEDBACK_MULTIPLY_VALUE_POS +: FEEDBACK_MULTIPLY_VALUE_W] = next_s.loop.feedback_multiply_value;
				rd_val[K2_POS +: K2_W] = next_s.loop.k2;
			end
			STATUS_ADDR: begin
				rd_val[SEL_POS +: 2] = next_s.sys.sel;
				rd_val[LOCK_POS] = s.locked;
				rd_val[STEP_POS +: ACC_W] = s.step;
			end
			default: begin
				rd_val = '0;
			end
		endcase

		// address phase
		next_s.hreadyout = 1'b1;
		next_s.hresp = 1'b0;
		if (hready) begin
			next_s.dp_valid = addr_take;
			next_s.dp_write = hwrite;
			next_s.dp_addr = haddr;
			if (addr_take && !hwrite) begin
				next_s.hrdata = rd_val;
			end
		end
	end

	// ------------------------------------------------------------
	// registers
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s <= '0;
			s.sys.sel <= SEL_RST;
			s.loop.bypass <= BYP_RST;
			s.step <= STEP_MIN_LOW;
		end else begin
			s <= next_s;
		end
	end

	assign hreadyout    = s.hreadyout;
	assign hrdata       = s.hrdata;
	assign hresp        = s.hresp;
	assign system_clock = s.sys_clock;
	assign loop_locked  = s.locked;

endmodule // ckg_system_clock_source_select

// *** tb/ckg_checker.sv ***
// port checker of the system clock source select block
module ckg_checker
	import ckg_pkg::*;
(
	// clock and reset
	input wire logic        clk,
	input wire logic        rstn,
	// clock sources
	input wire logic        direct_clock_pin,
	input wire logic        oscillator_input_pin,
	input wire logic        internal_clock_source,
	input wire logic        wakeup_clock_source,
	// bus
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic [31:0] hrdata,
	input wire logic        hresp,
	// results
	input wire logic        system_clock,
	input wire logic        loop_locked
);
	// --------
	// shadow of the written setup
	// --------
	logic [1:0]  sel;
	logic        byp;
	logic        rf;
	logic        aw;
	logic [31:0] ap;
	logic [9:0]  k1;
	logic [2:0]  settle;
	wire         rd_take = hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
	wire         refp = rf ? internal_clock_source : oscillator_input_pin;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			aw <= 1'b0;
			ap <= '0;
			sel <= SEL_RST;
			byp <= BYP_RST;
			rf <= 1'b0;
			k1 <= '0;
			settle <= '0;
		end else begin
			aw <= hsel && hready && htrans == HTRANS_NONSEQ && hwrite;
			ap <= haddr;
			if (aw && ap == SYS_CTRL_ADDR && hwdata[1:0] != SEL_RESERVED)
				sel <= hwdata[1:0];
			if (aw && ap == SYS_CTRL_ADDR)
				k1 <= hwdata[25:16];
			if (aw && ap == LOOP_CTRL_ADDR)
				byp <= hwdata[0];
			if (aw && ap == LOOP_CTRL_ADDR)
				rf <= hwdata[3];
			// any write restarts the settle count, cheap and safe
			settle <= aw ? 3'h0 : settle + {2'h0, settle != 3'h7};
		end
	end

	// --------
	// assertions
	// --------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	resp_okay_a: assert property (!hresp)
		else $error("response not okay");
	ready_high_a: assert property ($past(rstn) |-> hreadyout)
		else $error("slave not ready");
	rdata_hold_a: assert property ($past(rstn) && !$past(rd_take) |-> $stable(hrdata))
		else $error("read data moved without a read");
	direct_pass_a: assert property (
		sel == SEL_DIRECT && settle >= 3'h2 |-> system_clock == $past(direct_clock_pin))
		else $error("system clock not the direct pin");
	wake_pass_a: assert property (
		sel == SEL_WAKEUP && settle >= 3'h2 |-> system_clock == $past(wakeup_clock_source))
		else $error("system clock not the wakeup source");
	presc_unity_a: assert property (
		sel == SEL_OSC && byp && k1 == 10'h0 && settle >= 3'h3
		|-> system_clock == $past(refp, 2))
		else $error("unity prescaler does not pass the reference");
	lock_off_a: assert property (
		!(sel == SEL_OSC && !byp) && settle >= 3'h2 |-> !loop_locked)
		else $error("lock shown outside loop mode");
	sel_keep_a: assert property (
		rd_take && (haddr == SYS_CTRL_ADDR || haddr == STATUS_ADDR)
		|=> hrdata[1:0] == sel)
		else $error("select readback differs");
	band_legal_a: assert property (
		rd_take && haddr == LOOP_CTRL_ADDR |=> !hrdata[2])
		else $error("reserved band stored");
endmodule // ckg_checker

bind ckg_system_clock_source_select ckg_checker u_chk (
	.clk                   (clk),
	.rstn                  (rstn),
	.direct_clock_pin      (direct_clock_pin),
	.oscillator_input_pin  (oscillator_input_pin),
	.internal_clock_source (internal_clock_source),
	.wakeup_clock_source   (wakeup_clock_source),
	.hsel                  (hsel),
	.haddr                 (haddr),
	.htrans                (htrans),
	.hwrite                (hwrite),
	.hwdata                (hwdata),
	.hready                (hready),
	.hreadyout             (hreadyout),
	.hrdata                (hrdata),
	.hresp                 (hresp),
	.system_clock          (system_clock),
	.loop_locked           (loop_locked)
);

// *** tb/system_clock_source_select_bench.sv ***
// testbench of the system clock source select block
module system_clock_source_select_bench
	import ckg_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk = 1'b0;
	logic        rstn = 1'b0;
	logic        dir = 1'b0;
	logic        osc = 1'b0;
	logic        intl = 1'b0;
	logic        wak = 1'b0;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = '0;
	logic [31:0] hwdata = '0;
	wire         hreadyout;
	wire         hresp;
	wire         system_clock;
	wire         loop_locked;
	wire  [31:0] hrdata;
	int          n_mismatch = 0;
	int          n_compared = 0;
	int          oh = 2;
	int          oc = 0;
	int          dc = 0;
	int          wc = 0;
	int          wt = 0;
	int          lim = 20000;

	ckg_system_clock_source_select u_dut (.clk(clk), .rstn(rstn),
		.direct_clock_pin(dir), .oscillator_input_pin(osc),
		.internal_clock_source(intl), .wakeup_clock_source(wak),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.system_clock(system_clock), .loop_locked(loop_locked));

	// --------
	// clock and source pins
	// --------
	always #12.5 clk = ~clk;

	always @(posedge clk) begin
		intl <= ~intl;
		dc <= (dc == 2) ? 0 : dc + 1;
		wc <= (wc == 4) ? 0 : wc + 1;
		oc <= (oc >= oh - 1) ? 0 : oc + 1;
		if (dc == 2)
			dir <= ~dir;
		if (wc == 4)
			wak <= ~wak;
		if (oc >= oh - 1)
			osc <= ~osc;
	end

	// --------
	// shared tasks
	// --------
	task close_out;
		$display("mismatches %0d compared %0d", n_mismatch, n_compared);
		if (n_mismatch == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s exp %h got %h", nm, exp, got);
		end
	endtask

	task tick;
		@(posedge clk);
		wt++;
		if (wt > lim) begin
			n_mismatch++;
			$display("[FAIL] wait timed out");
			close_out;
		end
	endtask

	task bus(input logic w, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= HTRANS_NONSEQ;
		wt = 0;
		do tick; while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wt = 0;
		do tick; while (hreadyout !== 1'b1);
		q = hrdata;
	endtask

	task wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task rd(input logic [31:0] a, output logic [31:0] q);
		bus(1'b0, a, 32'h0, q);
	endtask

	task rise;
		while (system_clock !== 1'b0)
			tick;
		while (system_clock !== 1'b1)
			tick;
	endtask

	// first two rises skipped: a divider may be mid-count after a switch
	task per(output int p);
		wt = 0;
		rise;
		rise;
		wt = 0;
		rise;
		p = wt;
	endtask

	// --------
	// scenarios
	// --------
	task t_regs;
		logic [31:0] q;
		rd(SYS_CTRL_ADDR, q);
		chk("sys reset", 32'h0, q);
		rd(LOOP_CTRL_ADDR, q);
		chk("loop reset", 32'h1, q);
		wr(32'h10, 32'hffff_ffff);
		rd(32'h10, q);
		chk("unmapped", 32'h0, q);
		wr(LOOP_CTRL_ADDR, 32'h5);
		rd(LOOP_CTRL_ADDR, q);
		chk("band 1x", 32'h1, q);
		wr(SYS_CTRL_ADDR, 32'h1);
		rd(STATUS_ADDR, q);
		chk("reserved sel", 32'h0, {30'h0, q[1:0]});
		$display("test regs done");
	endtask

	task t_src;
		int p;
		wr(SYS_CTRL_ADDR, 32'h3);
		per(p);
		chk("direct period", 32'd6, p);
		wr(SYS_CTRL_ADDR, 32'h1);
		per(p);
		chk("reserved keeps", 32'd6, p);
		wr(SYS_CTRL_ADDR, 32'h0);
		per(p);
		chk("wakeup period", 32'd10, p);
		$display("test sources done");
	endtask

	task pre(input logic ri, input logic [9:0] k, input int exp);
		int p;
		wr(LOOP_CTRL_ADDR, {28'h0, ri, 3'h1});
		wr(SYS_CTRL_ADDR, {6'h0, k, 14'h0, SEL_OSC});
		per(p);
		chk("prescaler period", exp, p);
	endtask

	task t_loop;
		logic [31:0] q;
		logic [31:0] r;
		oh = 30;
		wr(LOOP_CTRL_ADDR, 32'h0001_0100);
		lim = 70000;
		wt = 0;
		while (loop_locked !== 1'b1)
			tick;
		wt = 0;
		rise;
		rise;
		wt = 0;
		repeat (4) rise;
		chk("loop period", 32'h1, (wt >= 234 && wt <= 246));
		rd(STATUS_ADDR, q);
		rd(STATUS_ADDR, r);
		chk("locked bit", 32'h1, q[2]);
		chk("step in band", 32'h1,
			q[31:16] >= STEP_MIN_LOW && q[31:16] <= STEP_MAX_LOW);
		chk("step smooth", 32'h1, (r[31:16] - q[31:16] + 16'h1) <= 16'h2);
		$display("test loop done");
	endtask

	initial begin
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		t_regs;
		t_src;
		pre(1'b1, 10'h0, 2);
		pre(1'b0, 10'h2, 12);
		pre(1'b0, 10'h3ff, 4096);
		$display("test prescaler done");
		t_loop;
		close_out;
	end
endmodule // system_clock_source_select_bench
